// >>> hdl/spcfg_status_mux.sv
// Status source selector with polarity for the status pin
// Assumes status inputs already synchronous to clock
`timescale 1ns/10ps
module spcfg_status_mux
  import spcfg_pkg::*;
(
  input  wire logic [4:0]    sel,
  input  wire logic          pol,
  input  wire spcfg_status_s sts,
  output logic               value
);
  logic raw;

  always_comb begin
    unique case (sel)
      SEL_PLL_LOCK: raw = sts.pll_lock;
      SEL_REF0_LOS: raw = sts.ref0_loss_monitor;
      SEL_XTAL_LOS: raw = sts.xtal_loss_monitor;
      SEL_REF0_ACT: raw = sts.ref0_activity_monitor;
      SEL_REF0_INV: raw = sts.ref0_invalid;
      SEL_DEV_INT:  raw = sts.device_int;
      SEL_READY:    raw = sts.ready;
      SEL_HIGH:     raw = 1'b1;
      default:      raw = 1'b0;
    endcase
  end

  // Polarity ignored for the top select code
  assign value = (sel == SEL_NOPOL) ? raw : (raw ^ pol);
endmodule

// >>> hdl/spcfg_top.sv
// Status pin and pad configuration: registers, startup hold, pin drive
// Assumes a register port from the serial processor port on the same clock
// Operation
// - Hold field zero keeps clock output drivers disabled until PLL lock.
// - Hold field two never gates drivers on lock; one and three reserved.
// - Push-pull strength, reset two, drives status pin and 3-wire data pin.
// - Open-drain strength, reset three, sets status pin pull-down drive.
// - Data pin pull-up enabled while its bit is one; resets one.
// - Clock pin pull-up enabled while its bit is one; resets one.
// - Open-drain, polarity zero: pin low for value 0, released for 1.
// - Open-drain, polarity one: pin low for value 1, released for 0.
// - Tristate bit one puts status pin in high impedance.
// - Status pin pull-down enabled while its bit is one.
// - Weak status pin pull-up enabled while its bit is one; resets one.
// - Polarity zero passes true value, one inverts it.
// - Polarity ignored when source select is 0x1F.
// - Select routes lock, ref0 loss, xtal loss, ref0 activity, ref0 invalid.
// - Select 0x9 outputs interrupt status ANDed with interrupt enable.
// - Select 0xA outputs ready once startup has completed.
// - Select 0x1D gives low, 0x1E gives high; others reserved.
`timescale 1ns/10ps
module spcfg_top
  import spcfg_pkg::*;
#(
  parameter int INT_W = 8
)(
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [0:0]         reg_sel,
  input  wire logic [15:0]        reg_wdata,
  output logic [15:0]             reg_rdata,
  input  wire logic               pll_lock_raw,
  input  wire logic               ref0_loss_raw,
  input  wire logic               xtal_loss_raw,
  input  wire logic               ref0_act_raw,
  input  wire logic               ref0_inv_raw,
  input  wire logic [INT_W-1:0]   int_status,
  input  wire logic [INT_W-1:0]   int_enable,
  input  wire logic               startup_done,
  input  wire logic               spi_3wire,
  input  wire logic               data_pin_drive,
  output spcfg_pad_s              status_pad,
  output spcfg_pad_s              data_pad,
  output logic                    clock_pin_pullup_en,
  output logic                    clkout_enable
);
  // ***************************************************************
  // Parameter check
  // ***************************************************************
  if (INT_W < 1) begin : g_bad_int
    $error("INT_W must be at least one");
  end

  // ***************************************************************
  // Synchronisers for analog monitor levels
  // ***************************************************************
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  wire  [NSYNC-1:0] async_in = {pll_lock_raw, ref0_loss_raw, xtal_loss_raw,
                                ref0_act_raw, ref0_inv_raw};

  // Only sync2 is read by logic outside this synchroniser
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (clk_en) begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0]  pad_misc_config_ff;
  logic [15:0] status_pin_config_ff;
  logic [7:0]  nxt_pad_misc_config;
  logic [15:0] nxt_status_pin_config;

  wire wr_pad = clk_en & reg_wr & (reg_sel == REG_PAD_MISC);
  wire wr_sp  = clk_en & reg_wr & (reg_sel == REG_STATUS_PIN);

  assign nxt_pad_misc_config = wr_pad ? (reg_wdata[7:0] & PAD_MISC_WMASK)
                                      : pad_misc_config_ff;
  // Reserved bits stay zero
  assign nxt_status_pin_config = wr_sp ? (reg_wdata & STATUS_PIN_WMASK)
                                       : status_pin_config_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pad_misc_config_ff   <= PAD_MISC_RST;
      status_pin_config_ff <= STATUS_PIN_RST;
    end else begin
      pad_misc_config_ff   <= nxt_pad_misc_config;
      status_pin_config_ff <= nxt_status_pin_config;
    end
  end

  // ***************************************************************
  // Field decode
  // ***************************************************************
  wire [1:0] startup_hold            = pad_misc_config_ff[STARTUP_HI:STARTUP_LO];
  wire [1:0] pushpull_strength       = pad_misc_config_ff[PP_HI:PP_LO];
  wire [1:0] opendrain_strength      = pad_misc_config_ff[OD_HI:OD_LO];
  wire       data_pin_pullup_en      = pad_misc_config_ff[DATA_PU];
  wire       status_pin_opendrain_en = status_pin_config_ff[SP_OD];
  wire       status_pin_hiz          = status_pin_config_ff[SP_HIZ];
  wire       status_pin_pulldown_en  = status_pin_config_ff[SP_PD];
  wire       status_pin_pullup_en    = status_pin_config_ff[SP_PU];
  wire       status_pol              = status_pin_config_ff[SP_POL];
  wire [4:0] status_sel              = status_pin_config_ff[SEL_HI:SEL_LO];

  // ***************************************************************
  // Status selection
  // ***************************************************************
  spcfg_status_s sts;
  logic          sel_value;

  assign sts.pll_lock              = sync2_ff[4];
  assign sts.ref0_loss_monitor     = sync2_ff[3];
  assign sts.xtal_loss_monitor     = sync2_ff[2];
  assign sts.ref0_activity_monitor = sync2_ff[1];
  assign sts.ref0_invalid          = sync2_ff[0];
  assign sts.device_int            = |(int_status & int_enable);
  assign sts.ready                 = startup_done;

  spcfg_status_mux u_spcfg_status_mux (
    .sel   (status_sel),
    .pol   (status_pol),
    .sts   (sts),
    .value (sel_value)
  );

  // ***************************************************************
  // Status pin drive, registered
  // ***************************************************************
  logic status_oe_ff;
  logic status_out_ff;
  wire  nxt_status_oe  = status_pin_hiz ? 1'b0 :
                         status_pin_opendrain_en ? ~sel_value : 1'b1;
  wire  nxt_status_out = status_pin_opendrain_en ? 1'b0 : sel_value;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_oe_ff  <= 1'b0;
      status_out_ff <= 1'b0;
    end else if (clk_en) begin
      status_oe_ff  <= nxt_status_oe;
      status_out_ff <= nxt_status_out;
    end
  end

  assign status_pad.out_en      = status_oe_ff;
  assign status_pad.in_b        = status_out_ff;
  assign status_pad.pullup_en   = status_pin_pullup_en;
  assign status_pad.pulldown_en = status_pin_pulldown_en;
  // Strength follows the active drive mode
  assign status_pad.strength    = status_pin_opendrain_en ? opendrain_strength
                                                          : pushpull_strength;

  // Data pin only takes push-pull strength in 3-wire SPI
  assign data_pad.out_en      = 1'b0;
  assign data_pad.in_b        = data_pin_drive;
  assign data_pad.pullup_en   = data_pin_pullup_en;
  assign data_pad.pulldown_en = 1'b0;
  assign data_pad.strength    = spi_3wire ? pushpull_strength : 2'h0;
  assign clock_pin_pullup_en  = pad_misc_config_ff[CLK_PU];

  // ***************************************************************
  // Startup output hold
  // ***************************************************************
  spcfg_state_e state_ff;
  spcfg_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SPCFG_HOLD: if (startup_hold != HOLD_UNTIL_LOCK || sts.pll_lock) begin
        nxt_state = SPCFG_RUN;
      end
      SPCFG_RUN:  nxt_state = SPCFG_RUN;
      default:    nxt_state = SPCFG_HOLD;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= SPCFG_HOLD;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // Hold only during startup; once running, later lock loss does not gate
  assign clkout_enable = (state_ff == SPCFG_RUN);

  // ***************************************************************
  // Read data, registered
  // ***************************************************************
  logic [15:0] rdata_ff;
  wire  [15:0] rd_mux = (reg_sel == REG_PAD_MISC) ? {8'h00, pad_misc_config_ff}
                                                  : status_pin_config_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 16'h0000;
    end else if (clk_en && reg_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  assign reg_rdata = rdata_ff;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_hold_until_lock;
    @(posedge clock) disable iff (!rst_b)
      (state_ff == SPCFG_HOLD && startup_hold == HOLD_UNTIL_LOCK && !sts.pll_lock)
      |=> !clkout_enable;
  endproperty
  a_hold_until_lock: assert property (p_hold_until_lock)
    else $error("Clock outputs enabled before lock");

  property p_no_hold;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && startup_hold == HOLD_NONE) |=> clkout_enable;
  endproperty
  a_no_hold: assert property (p_no_hold)
    else $error("Clock outputs held with hold disabled");

  property p_od_strength;
    @(posedge clock) disable iff (!rst_b)
      status_pin_opendrain_en |-> status_pad.strength == opendrain_strength;
  endproperty
  a_od_strength: assert property (p_od_strength)
    else $error("Open-drain strength not applied");

  property p_pp_strength;
    @(posedge clock) disable iff (!rst_b)
      (!status_pin_opendrain_en && spi_3wire)
      |-> (status_pad.strength == pushpull_strength && data_pad.strength == pushpull_strength);
  endproperty
  a_pp_strength: assert property (p_pp_strength)
    else $error("Push-pull strength not applied");

  property p_hiz;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && status_pin_hiz) |=> !status_pad.out_en;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("Status pin driven while tristated");

  property p_od_pol0;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && !status_pin_hiz && status_pin_opendrain_en && !status_pol
       && status_sel == SEL_LOW)
      |=> (status_pad.out_en && !status_pad.in_b);
  endproperty
  a_od_pol0: assert property (p_od_pol0)
    else $error("Open-drain pin not pulled low for value zero");

  property p_od_pol1;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && status_pin_opendrain_en && status_pol && status_sel == SEL_LOW)
      |=> !status_pad.out_en;
  endproperty
  a_od_pol1: assert property (p_od_pol1)
    else $error("Open-drain pin not released under inversion");

  property p_pp_high;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && !status_pin_hiz && !status_pin_opendrain_en && status_sel == SEL_HIGH
       && !status_pol) |=> (status_pad.out_en && status_pad.in_b);
  endproperty
  a_pp_high: assert property (p_pp_high)
    else $error("Constant high not driven");

  property p_nopol;
    @(posedge clock) disable iff (!rst_b)
      (status_sel == SEL_NOPOL) |-> !sel_value;
  endproperty
  a_nopol: assert property (p_nopol)
    else $error("Polarity applied on select 0x1F");

  property p_int;
    @(posedge clock) disable iff (!rst_b)
      (status_sel == SEL_DEV_INT && !status_pol)
      |-> sel_value == |(int_status & int_enable);
  endproperty
  a_int: assert property (p_int)
    else $error("Interrupt source mismatch");

  // Checked against the written data, not the register, so a broken write path shows
  property p_data_pullup;
    @(posedge clock) disable iff (!rst_b)
      wr_pad |=> (data_pad.pullup_en == $past(reg_wdata[DATA_PU]));
  endproperty
  a_data_pullup: assert property (p_data_pullup)
    else $error("Data pin pull-up does not follow its bit");

  property p_clock_pullup;
    @(posedge clock) disable iff (!rst_b)
      wr_pad |=> (clock_pin_pullup_en == $past(reg_wdata[CLK_PU]));
  endproperty
  a_clock_pullup: assert property (p_clock_pullup)
    else $error("Clock pin pull-up does not follow its bit");

  property p_pullups;
    @(posedge clock) disable iff (!rst_b)
      wr_sp |=> ((status_pad.pullup_en == $past(reg_wdata[SP_PU]))
                 && (status_pad.pulldown_en == $past(reg_wdata[SP_PD])));
  endproperty
  a_pullups: assert property (p_pullups)
    else $error("Pull resistor enable mismatch");

  property p_ready;
    @(posedge clock) disable iff (!rst_b)
      (status_sel == SEL_READY && !status_pol) |-> (sel_value == startup_done);
  endproperty
  a_ready: assert property (p_ready)
    else $error("Ready source mismatch");

  property p_pol_inv;
    @(posedge clock) disable iff (!rst_b)
      (status_sel == SEL_HIGH && status_pol) |-> !sel_value;
  endproperty
  a_pol_inv: assert property (p_pol_inv)
    else $error("Polarity not applied");

  // Enable low must freeze pin, state, read data and the status pin register alike
  property p_freeze;
    @(posedge clock) disable iff (!rst_b)
      !clk_en |=> ($stable(state_ff) && $stable(status_oe_ff) && $stable(status_out_ff)
                   && $stable(rdata_ff) && $stable(status_pin_config_ff));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State moved with clock enable low");

  c_lock_release: cover property (@(posedge clock) disable iff (!rst_b)
    state_ff == SPCFG_HOLD ##1 state_ff == SPCFG_RUN);
  c_od_release: cover property (@(posedge clock) disable iff (!rst_b)
    status_pin_opendrain_en && !status_pad.out_en);
  c_hiz: cover property (@(posedge clock) disable iff (!rst_b) status_pin_hiz);
  c_ready: cover property (@(posedge clock) disable iff (!rst_b)
    status_sel == SEL_READY && sel_value);
  c_od_low: cover property (@(posedge clock) disable iff (!rst_b)
    status_pin_opendrain_en && status_pad.out_en && !status_pad.in_b);
endmodule

// >>> inc/spcfg_pkg.sv
// Package for the status pin and pad configuration block
// Assumes a register write/read port from the serial processor port decoder
package spcfg_pkg;
  // ***************************************************************
  // Register identifiers
  // ***************************************************************
  localparam logic [0:0] REG_PAD_MISC   = 1'h0;
  localparam logic [0:0] REG_STATUS_PIN = 1'h1;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int STARTUP_HI = 7;
  localparam int STARTUP_LO = 6;
  localparam int PP_HI      = 5;
  localparam int PP_LO      = 4;
  localparam int OD_HI      = 3;
  localparam int OD_LO      = 2;
  localparam int DATA_PU    = 1;
  localparam int CLK_PU     = 0;
  localparam int SP_OD      = 12;
  localparam int SP_HIZ     = 11;
  localparam int SP_PD      = 10;
  localparam int SP_PU      = 9;
  localparam int SP_POL     = 8;
  localparam int SEL_HI     = 4;
  localparam int SEL_LO     = 0;
  localparam logic [7:0]  PAD_MISC_RST   = 8'h2f;
  localparam logic [15:0] STATUS_PIN_RST = 16'h0200;
  localparam logic [7:0]  PAD_MISC_WMASK   = 8'hff;
  localparam logic [15:0] STATUS_PIN_WMASK = 16'h1f1f;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  localparam logic [1:0] HOLD_UNTIL_LOCK = 2'h0;
  localparam logic [1:0] HOLD_NONE       = 2'h2;
  localparam logic [4:0] SEL_PLL_LOCK  = 5'h00;
  localparam logic [4:0] SEL_REF0_LOS  = 5'h02;
  localparam logic [4:0] SEL_XTAL_LOS  = 5'h04;
  localparam logic [4:0] SEL_REF0_ACT  = 5'h05;
  localparam logic [4:0] SEL_REF0_INV  = 5'h07;
  localparam logic [4:0] SEL_DEV_INT   = 5'h09;
  localparam logic [4:0] SEL_READY     = 5'h0a;
  localparam logic [4:0] SEL_LOW       = 5'h1d;
  localparam logic [4:0] SEL_HIGH      = 5'h1e;
  localparam logic [4:0] SEL_NOPOL     = 5'h1f;

  typedef struct packed {
    logic       pll_lock;
    logic       ref0_loss_monitor;
    logic       xtal_loss_monitor;
    logic       ref0_activity_monitor;
    logic       ref0_invalid;
    logic       device_int;
    logic       ready;
  } spcfg_status_s;

  typedef struct packed {
    logic       out_en;
    logic       in_b;
    logic       pullup_en;
    logic       pulldown_en;
    logic [1:0] strength;
  } spcfg_pad_s;

  typedef enum logic [1:0] {
    SPCFG_HOLD = 2'b00,
    SPCFG_RUN  = 2'b01
  } spcfg_state_e;
endpackage

// >>> tb/spcfg_host_model.sv
// Host-side model of the board watching the status pin
// Assumes status_pad comes straight from spcfg_top, same clock
`timescale 1ns/10ps
module spcfg_host_model
  import spcfg_pkg::*;
#(
  parameter bit EXT_PULLUP = 1'b1
)(
  input  wire logic       clock,
  input  wire spcfg_pad_s status_pad,
  output logic            status_line
);
  // ***************************************************************
  // Wire level seen by the host
  // ***************************************************************
  logic last_ff = 1'b0;

  // Board pull-up holds an open-drain line; with none the level wanders
  assign status_line = status_pad.out_en ? status_pad.in_b :
                       status_pad.pulldown_en ? 1'b0 :
                       (status_pad.pullup_en | EXT_PULLUP) ? 1'b1 : ~last_ff;

  always_ff @(posedge clock) begin
    last_ff <= status_line;
  end
endmodule

// >>> tb/spcfg_top_tb_top.sv
// Self-checking bench for the status pin and pad configuration block
// Assumes the design package and a host model on the status pin
`timescale 1ns/10ps
module spcfg_top_tb_top;
  import spcfg_pkg::*;
  logic        clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        spi_3wire = 1'b0, data_pin_drive = 1'b0, startup_done = 1'b0;
  logic [0:0]  reg_sel = 1'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_val;
  logic [4:0]  raw_v = 5'h00;
  logic [7:0]  int_status = 8'h00, int_enable = 8'h00;
  spcfg_pad_s  status_pad, data_pad;
  logic        clock_pin_pullup_en, clkout_enable, status_line;
  int          num_errors = 0, n_compared = 0;

  initial begin
    forever #12.5 clock = ~clock;
  end

  spcfg_top #(.INT_W(8)) u_spcfg_top (
    .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pll_lock_raw(raw_v[0]), .ref0_loss_raw(raw_v[1]), .xtal_loss_raw(raw_v[2]),
    .ref0_act_raw(raw_v[3]), .ref0_inv_raw(raw_v[4]), .int_status(int_status),
    .int_enable(int_enable), .startup_done(startup_done), .spi_3wire(spi_3wire),
    .data_pin_drive(data_pin_drive), .status_pad(status_pad), .data_pad(data_pad),
    .clock_pin_pullup_en(clock_pin_pullup_en), .clkout_enable(clkout_enable));

  spcfg_host_model u_spcfg_host_model (
    .clock(clock), .status_pad(status_pad), .status_line(status_line));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic tally_and_finish();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask

  // Inputs move 2 ns after the edge, so every edge sees settled values
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // Strobe drops one edge before the next access may raise it
  task automatic wr(input logic [0:0] sel, input logic [15:0] data);
    reg_sel = sel;
    reg_wdata = data;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [0:0] sel);
    reg_sel = sel;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    rd_val = reg_rdata;
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    step(16);
    rst_b = 1'b1;
  endtask

  function automatic logic [15:0] scfg(input logic od, hiz, pd, pol, input logic [4:0] sel);
    return {3'h0, od, hiz, pd, 1'b1, pol, 3'h0, sel};
  endfunction

  // Settle covers write, two sync flops and the pin register
  task automatic set_pin(input logic [15:0] cfg);
    wr(1'h1, cfg);
    step(6);
  endtask

  task automatic pin(input logic oe, input logic lvl);
    chk("status out_en", status_pad.out_en, oe);
    chk("status line", status_line, lvl);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset();
    rd(1'h0);
    chk("pad_misc reset", rd_val, 16'h002f);
    rd(1'h1);
    chk("status_pin reset", rd_val, 16'h0200);
    chk("status pullup", status_pad.pullup_en, 1'b1);
    chk("status pulldown", status_pad.pulldown_en, 1'b0);
    chk("status strength", status_pad.strength, 2'h2);
    chk("data pullup", data_pad.pullup_en, 1'b1);
    chk("clock pullup", clock_pin_pullup_en, 1'b1);
    chk("data out_en", data_pad.out_en, 1'b0);
    chk("data pulldown", data_pad.pulldown_en, 1'b0);
  endtask

  task automatic t_startup();
    int k;
    step(10);
    chk("clkout held", clkout_enable, 1'b0);
    raw_v[0] = 1'b1;
    for (k = 0; k < 8 && clkout_enable !== 1'b1; k++) begin
      step(1);
    end
    if (k == 8) begin
      num_errors++;
      tally_and_finish();
    end
    raw_v[0] = 1'b0;
    step(4);
    chk("clkout sticky", clkout_enable, 1'b1);
    do_reset();
    chk("clkout after reset", clkout_enable, 1'b0);
    wr(1'h0, 16'h00af);
    step(4);
    chk("clkout no gating", clkout_enable, 1'b1);
  endtask

  task automatic t_regs();
    set_pin(16'hffff);
    rd(1'h1);
    chk("status_pin mask", rd_val, 16'h1f1f);
    chk("pulldown on", status_pad.pulldown_en, 1'b1);
    pin(1'b0, 1'b0);
    clk_en = 1'b0;
    wr(1'h1, 16'h0000);
    clk_en = 1'b1;
    rd(1'h1);
    chk("frozen write", rd_val, 16'h1f1f);
  endtask

  task automatic t_sources();
    logic [4:0] sels [5] = '{SEL_PLL_LOCK, SEL_REF0_LOS, SEL_XTAL_LOS, SEL_REF0_ACT, SEL_REF0_INV};
    for (int i = 0; i < 5; i++) begin
      raw_v = 5'h01 << i;
      set_pin(scfg(1'b0, 1'b0, 1'b0, 1'b0, sels[i]));
      pin(1'b1, 1'b1);
      raw_v = ~(5'h01 << i);
      step(6);
      pin(1'b1, 1'b0);
      set_pin(scfg(1'b0, 1'b0, 1'b0, 1'b1, sels[i]));
      pin(1'b1, 1'b1);
    end
    raw_v = 5'h00;
    int_status = 8'h0f;
    int_enable = 8'hf0;
    set_pin(scfg(1'b0, 1'b0, 1'b0, 1'b0, SEL_DEV_INT));
    pin(1'b1, 1'b0);
    int_enable = 8'h18;
    step(4);
    pin(1'b1, 1'b1);
    set_pin(scfg(1'b0, 1'b0, 1'b0, 1'b0, SEL_READY));
    pin(1'b1, 1'b0);
    startup_done = 1'b1;
    step(4);
    pin(1'b1, 1'b1);
  endtask

  task automatic t_const();
    logic [4:0] sel [9] = '{5'h1d, 5'h1e, 5'h1e, 5'h1f, 5'h1f, 5'h1d, 5'h1e, 5'h1e, 5'h1d};
    logic       od  [9] = '{0, 0, 0, 0, 0, 1, 1, 1, 1};
    logic       pol [9] = '{0, 0, 1, 0, 1, 0, 0, 1, 1};
    logic       lvl [9] = '{0, 1, 0, 0, 0, 0, 1, 0, 1};
    for (int i = 0; i < 9; i++) begin
      set_pin(scfg(od[i], 1'b0, 1'b0, pol[i], sel[i]));
      pin(od[i] ? !lvl[i] : 1'b1, lvl[i]);
      chk("status strength", status_pad.strength, od[i] ? 2'h3 : 2'h2);
    end
  endtask

  task automatic t_pads();
    wr(1'h0, 16'h0034);
    chk("data pullup off", data_pad.pullup_en, 1'b0);
    chk("clock pullup off", clock_pin_pullup_en, 1'b0);
    chk("od strength", status_pad.strength, 2'h1);
    spi_3wire = 1'b1;
    data_pin_drive = 1'b1;
    step(1);
    chk("data strength 3wire", data_pad.strength, 2'h3);
    chk("data level", data_pad.in_b, 1'b1);
    // Push-pull status pin with 3-wire on, so both pads share the strength
    set_pin(scfg(1'b0, 1'b0, 1'b0, 1'b0, SEL_HIGH));
    chk("pp strength", status_pad.strength, 2'h3);
    chk("data strength pp", data_pad.strength, 2'h3);
    spi_3wire = 1'b0;
    step(1);
    chk("data strength 4wire", data_pad.strength, 2'h0);
    set_pin(scfg(1'b0, 1'b1, 1'b0, 1'b0, SEL_LOW));
    pin(1'b0, 1'b1);
  endtask

  initial begin
    step(16);
    rst_b = 1'b1;
    t_reset();
    t_startup();
    t_regs();
    t_sources();
    t_const();
    t_pads();
    tally_and_finish();
  end
endmodule
